// file: design/rce_top.sv
/*
  rce_top: per-phase startup calls, red clearance extension and
  advance warning beacon for one associated phase.
  assumes: phase interval levels and force-off come from the sequencer
  on clk; detector inputs are already synchronous and debounced.
*/
// Summary of operation
// - programmed startup places masked vehicle calls
// - programmed startup places masked pedestrian calls
// - accept trigger in late yellow window
// - zero window: only red clearance triggers
// - window above yellow: accept whole clearance
// - time extension from actuation to red end
// - hold all-red while detector or timer active
// - total red never exceeds the cap
// - speed trap may replace the detector
// - alarm while red extended past normal
// - force-off holds green, beacon for interval
// - beacon off in green, on from termination
// - coordinated warning terminates concurrent phases
// - beacon works free and coordinated
`timescale 1ns/10ps
`default_nettype none
module rce_top #(
  parameter int unsigned PHASES   = rce_pkg::PHASES,
  parameter int unsigned GROUPS   = rce_pkg::TRAP_GROUPS,
  parameter int unsigned TICK_DIV = rce_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // startup configuration
  input  wire logic                  use_programmed,
  input  wire logic [PHASES-1:0]     startup_vehicle_call_mask,
  input  wire logic [PHASES-1:0]     startup_pedestrian_call_mask,
  // startup calls out
  output logic      [PHASES-1:0]     startup_vehicle_call,
  output logic      [PHASES-1:0]     startup_pedestrian_call,
  // phase timing, tenth seconds
  input  wire logic [7:0]            yellow_time,
  input  wire logic [7:0]            red_time,
  input  wire logic [7:0]            late_yellow_window,
  input  wire logic [7:0]            clearance_extension_time,
  input  wire logic [7:0]            red_clearance_cap,
  // phase interval levels
  input  wire logic                  phase_green,
  input  wire logic                  phase_yellow,
  input  wire logic                  phase_red_clr,
  // extension triggers
  input  wire logic                  red_extend_detector,
  input  wire logic                  speed_trap_enable,
  input  wire logic [rce_pkg::TRAP_SEL_W-1:0] speed_trap_group,
  input  wire logic [7:0]            speed_threshold,
  input  wire logic [GROUPS*8-1:0]   speed_trap_speed,
  input  wire logic [GROUPS-1:0]     speed_trap_strobe,
  // red clearance outputs
  output logic                       red_hold,
  output logic                       red_extension_alarm,
  // beacon configuration and control
  input  wire logic [7:0]            warning_time,
  input  wire logic                  coordinated,
  input  wire logic                  force_off,
  // beacon outputs
  output logic                       hold_green,
  output logic                       beacon_out,
  output logic                       terminate_concurrent
);
  // refuse shapes the logic cannot serve
  if (PHASES < 1 || GROUPS < 1 || GROUPS > 2**rce_pkg::TRAP_SEL_W) begin : g_chk
    $error("rce_top: bad PHASES or GROUPS");
  end

  logic            tick;            // tenth-second enable
  logic            done_r;          // startup calls issued
  logic [PHASES-1:0] vcall_r;       // startup vehicle pulse
  logic [PHASES-1:0] pcall_r;       // startup ped pulse
  logic [7:0]      yel_el_r;        // ticks into yellow
  logic [7:0]      red_el_r;        // ticks into red clearance
  logic [7:0]      yel_left;        // ticks left in yellow
  logic            trap_hit;        // selected trap over threshold
  logic            trig;            // extension trigger level
  logic            yel_accept;      // trigger taken in yellow
  logic            red_accept;      // trigger taken in red
  logic            ext_load;        // restart extension timer
  logic [7:0]      ext_cnt;         // extension ticks left
  logic            ext_busy;        // extension timer running
  logic            at_normal_end;   // normal red time reached
  logic            alarm_r;         // registered alarm
  logic            grn_d_r;         // green last cycle
  logic            bcn_load;        // start warning interval
  logic            bcn_busy;        // warning interval running
  rce_pkg::rce_bcn_t bcn_r;         // beacon state
  rce_pkg::rce_bcn_t bcn_nxt;       // beacon next state

  // shared tenth-second base for every interval
  rce_tick #(.DIV(TICK_DIV)) u_tick (
    .clk   (clk),
    .rst_b (rst_b),
    .tick  (tick)
  );

  // one-shot calls in the first cycle after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r  <= 1'b0;
      vcall_r <= '0;
      pcall_r <= '0;
    end else if (!done_r) begin
      done_r  <= 1'b1;
      vcall_r <= use_programmed ? startup_vehicle_call_mask : '0;
      pcall_r <= use_programmed ? startup_pedestrian_call_mask : '0;
    end else begin
      vcall_r <= '0;
      pcall_r <= '0;
    end
  end

  assign startup_vehicle_call    = vcall_r;
  assign startup_pedestrian_call = pcall_r;

  // elapsed clock for yellow; saturates so long yellows stay safe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      yel_el_r <= rce_pkg::TIME_RST;
    end else if (!phase_yellow) begin
      yel_el_r <= rce_pkg::TIME_RST;
    end else if (tick && yel_el_r != rce_pkg::TIME_SAT) begin
      yel_el_r <= yel_el_r + 8'h01;
    end
  end

  // elapsed clock for red clearance, compared to normal end and cap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      red_el_r <= rce_pkg::TIME_RST;
    end else if (!phase_red_clr) begin
      red_el_r <= rce_pkg::TIME_RST;
    end else if (tick && red_el_r != rce_pkg::TIME_SAT) begin
      red_el_r <= red_el_r + 8'h01;
    end
  end

  // selected speed trap group against the threshold
  always_comb begin
    trap_hit = 1'b0;
    for (int g = 0; g < GROUPS; g++) begin
      if (speed_trap_group == rce_pkg::TRAP_SEL_W'(g) && speed_trap_strobe[g] &&
          speed_trap_speed[g*8 +: 8] >= speed_threshold) begin
        trap_hit = 1'b1;
      end
    end
  end

  // trap replaces the single detector when enabled
  assign trig = speed_trap_enable ? trap_hit : red_extend_detector;

  // remaining yellow; a window above yellow covers it all
  assign yel_left   = (yel_el_r >= yellow_time) ? 8'h00 : yellow_time - yel_el_r;
  assign yel_accept = phase_yellow && trig && late_yellow_window != 8'h00 &&
                      yel_left <= late_yellow_window;
  // red triggers count only while under the cap
  assign red_accept = phase_red_clr && trig && red_el_r < red_clearance_cap;
  assign ext_load   = yel_accept || red_accept;

  // extension interval from last actuation
  rce_dntimer #(.W(rce_pkg::TIME_W)) u_ext (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (tick),
    .load     (ext_load),
    .load_val (clearance_extension_time),
    .count    (ext_cnt),
    .busy     (ext_busy)
  );

  // hold past normal end; cap cuts the hold however often retriggered
  assign at_normal_end = phase_red_clr && red_el_r >= red_time;
  assign red_hold = at_normal_end && (trig || ext_busy) &&
                    red_el_r < red_clearance_cap;

  // alarm follows the hold by one cycle, drops when hold ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= red_hold;
    end
  end

  assign red_extension_alarm = alarm_r;

  // green edge detect for the beacon
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      grn_d_r <= 1'b0;
    end else begin
      grn_d_r <= phase_green;
    end
  end

  // warning interval starts on force-off in green, free or coordinated
  assign bcn_load = (bcn_r == rce_pkg::RCE_BCN_DARK) && force_off && phase_green;

  rce_dntimer #(.W(rce_pkg::TIME_W)) u_bcn (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (tick),
    .load     (bcn_load),
    .load_val (warning_time),
    .count    (),           // only busy matters: warning ends at zero
    .busy     (bcn_busy)
  );

  // beacon sequencing; new green always darkens it
  always_comb begin
    bcn_nxt = bcn_r;
    unique case (bcn_r)
      rce_pkg::RCE_BCN_DARK: begin
        if (bcn_load) begin
          bcn_nxt = rce_pkg::RCE_BCN_WARN;
        end else if (!phase_green && grn_d_r) begin
          bcn_nxt = rce_pkg::RCE_BCN_LIT;   // ended without force-off
        end
      end
      rce_pkg::RCE_BCN_WARN: begin
        if (!bcn_busy) begin
          bcn_nxt = rce_pkg::RCE_BCN_LIT;
        end
      end
      rce_pkg::RCE_BCN_LIT: begin
        if (phase_green && !grn_d_r) begin
          bcn_nxt = rce_pkg::RCE_BCN_DARK;
        end
      end
      default: begin
        bcn_nxt = rce_pkg::RCE_BCN_LIT;     // illegal code recovers lit
      end
    endcase
  end

  // beacon lit from power-up until first green
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bcn_r <= rce_pkg::RCE_BCN_LIT;
    end else begin
      bcn_r <= bcn_nxt;
    end
  end

  assign hold_green  = (bcn_r == rce_pkg::RCE_BCN_WARN);
  assign beacon_out  = (bcn_r != rce_pkg::RCE_BCN_DARK);
  // only the associated phase extends in coordination
  assign terminate_concurrent = hold_green && coordinated;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_warn_start;
    bcn_r == rce_pkg::RCE_BCN_DARK && force_off && phase_green && warning_time != 8'h00;
  endsequence
  sequence s_warn_on;
    hold_green && beacon_out;
  endsequence

  property p_start_veh;
    $rose(done_r) |-> startup_vehicle_call == ($past(use_programmed) ? $past(startup_vehicle_call_mask) : '0);
  endproperty
  a_start_veh: assert property (p_start_veh) else $error("startup vehicle call wrong");

  property p_start_ped;
    done_r && $past(done_r) |-> startup_pedestrian_call == '0 && startup_vehicle_call == '0;
  endproperty
  a_start_ped: assert property (p_start_ped) else $error("startup call repeated");

  property p_yel_load;
    yel_accept && !red_accept |=> ext_cnt == $past(clearance_extension_time);
  endproperty
  a_yel_load: assert property (p_yel_load) else $error("late yellow trigger not loaded");

  property p_zero_win;
    late_yellow_window == 8'h00 |-> !yel_accept;
  endproperty
  a_zero_win: assert property (p_zero_win) else $error("yellow trigger with zero window");

  property p_wide_win;
    phase_yellow && trig && late_yellow_window > yellow_time |-> ext_load;
  endproperty
  a_wide_win: assert property (p_wide_win) else $error("wide window trigger refused");

  property p_ext_step;
    ext_busy && tick && !ext_load |=> ext_cnt == $past(ext_cnt) - 8'h01;
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("extension timer did not step");

  property p_hold;
    at_normal_end && ext_busy && red_el_r < red_clearance_cap |-> red_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("all-red not held");

  property p_cap;
    red_hold |-> red_el_r < red_clearance_cap;
  endproperty
  a_cap: assert property (p_cap) else $error("red hold beyond cap");

  property p_alarm;
    red_hold || red_extension_alarm |=> red_extension_alarm == $past(red_hold);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm does not track extension");

  property p_warn;
    s_warn_start |=> s_warn_on;
  endproperty
  a_warn: assert property (p_warn) else $error("warning interval not started");

  property p_green_dark;
    bcn_r == rce_pkg::RCE_BCN_LIT && $rose(phase_green) |=> !beacon_out;
  endproperty
  a_green_dark: assert property (p_green_dark) else $error("beacon on in green");

  property p_term;
    hold_green && coordinated |-> terminate_concurrent;
  endproperty
  a_term: assert property (p_term) else $error("concurrent phase not terminated");
endmodule : rce_top
`default_nettype wire

// file: design/rce_pkg.sv
/*
  rce_pkg: shared constants for the red clearance extender.
  assumes: a single 20 MHz clock and tenth-of-a-second interval fields.
*/
`default_nettype none
package rce_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ       = 20000000;  // system clock rate
  localparam int unsigned TICK_MS      = 100;       // interval resolution, ms
  localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1000) * TICK_MS;
  // field widths and layout
  localparam int unsigned TIME_W       = 8;         // 0.0 .. 25.5 s in ticks
  localparam int unsigned PHASES       = 8;         // startup call mask width
  localparam int unsigned TRAP_GROUPS  = 4;         // speed trap groups
  localparam int unsigned TRAP_SEL_W   = 2;         // group selector width
  // values after reset
  localparam logic [7:0]  TIME_RST     = 8'h00;     // timers idle
  localparam logic [7:0]  TIME_SAT     = 8'hff;     // elapsed saturation
  // beacon states
  typedef enum logic [1:0] {
    RCE_BCN_DARK = 2'b00,  // phase green, beacon off
    RCE_BCN_WARN = 2'b01,  // warning interval, green held
    RCE_BCN_LIT  = 2'b10   // clearance onward, beacon on
  } rce_bcn_t;
endpackage : rce_pkg
`default_nettype wire

// file: design/rce_tick.sv
/*
  rce_tick: divides the system clock to a one-cycle tenth-second enable.
  assumes: DIV of at least 2; reset released synchronously to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module rce_tick #(
  parameter int unsigned DIV = rce_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // enable out
  output logic      tick
);
  localparam int unsigned CW = $clog2(DIV);

  // refuse a divider the counter cannot serve
  if (DIV < 2) begin : g_chk
    $error("rce_tick: DIV must be at least 2");
  end

  logic [CW-1:0] cnt_r;  // cycles within one tick
  logic          tick_r; // registered enable

  // free-running divider; pulse on wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == CW'(DIV - 1)) begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule : rce_tick
`default_nettype wire

// file: design/rce_dntimer.sv
/*
  rce_dntimer: loadable down counter stepping on the tick enable.
  assumes: load and tick are synchronous one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module rce_dntimer #(
  parameter int unsigned W = rce_pkg::TIME_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // control
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // status
  output logic      [W-1:0] count,
  output logic              busy
);
  if (W < 1) begin : g_chk
    $error("rce_dntimer: W must be positive");
  end

  logic [W-1:0] cnt_r;  // ticks left

  // load wins over a step in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (tick && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign count = cnt_r;
  assign busy  = (cnt_r != '0);
endmodule : rce_dntimer
`default_nettype wire

// file: dv/rce_phase_model.sv
/*
  rce_phase_model: behavioural sequencer for the associated phase.
  assumes: same clk, rst_b and tick period as the block under test.
*/
`timescale 1ns/10ps
`default_nettype none
module rce_phase_model #(
  parameter int unsigned DIV = 8
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // interval lengths, tenths
  input  wire logic [7:0] yellow_time,
  input  wire logic [7:0] red_time,
  // force-off, and requests from the block
  input  wire logic       force_off,
  input  wire logic       hold_green,
  input  wire logic       red_hold,
  // interval levels
  output logic            phase_green,
  output logic            phase_yellow,
  output logic            phase_red_clr
);
  logic [1:0]  st_r;   // 0 green, 1 yellow, 2 red
  logic [7:0]  el_r;   // ticks spent in interval
  logic [31:0] div_r;  // tick divider from reset
  logic        end_r;  // force-off pending
  logic        due_r;  // normal red end seen last cycle
  wire  logic  tk = (div_r == DIV - 1);
  assign phase_green   = (st_r == 2'h0);
  assign phase_yellow  = (st_r == 2'h1);
  assign phase_red_clr = (st_r == 2'h2);
  // tick divider, same period as the block's own
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_r <= '0;
    else div_r <= tk ? '0 : div_r + 32'h1;
  end
  // force-off latched until the block lets green go
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) end_r <= 1'b0;
    else end_r <= phase_green && (end_r || force_off);
  end
  // sequencer; red end waits one extra cycle so a tick skew
  // of one cycle against the block cannot cut a hold short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r  <= 2'h2;
      el_r  <= 8'h00;
      due_r <= 1'b0;
    end else begin
      el_r  <= tk ? el_r + 8'h01 : el_r;
      due_r <= phase_red_clr && (el_r >= red_time);
      if (phase_green && end_r && !hold_green) begin
        st_r <= 2'h1;
        el_r <= 8'h00;
      end else if (phase_yellow && el_r >= yellow_time) begin
        st_r <= 2'h2;
        el_r <= 8'h00;
      end else if (due_r && el_r >= red_time && !red_hold) begin
        st_r <= 2'h0;
        el_r <= 8'h00;
      end
    end
  end
endmodule : rce_phase_model
`default_nettype wire

// file: dv/red_clearance_extender_tb_top.sv
/*
  red_clearance_extender_tb_top: self-checking bench for rce_top.
  assumes: rce_phase_model sequences the phase on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module red_clearance_extender_tb_top;
  localparam int unsigned DIV = 8;  // short tick keeps the run brief
  logic        clk, rst_b, use_programmed, red_extend_detector, speed_trap_enable;
  logic        coordinated, force_off, phase_green, phase_yellow, phase_red_clr;
  logic        red_hold, red_extension_alarm, hold_green, beacon_out, terminate_concurrent;
  logic [7:0]  startup_vehicle_call_mask, startup_pedestrian_call_mask;
  logic [7:0]  startup_vehicle_call, startup_pedestrian_call, yellow_time, red_time;
  logic [7:0]  late_yellow_window, clearance_extension_time, red_clearance_cap;
  logic [7:0]  speed_threshold, warning_time;
  logic [1:0]  speed_trap_group;
  logic [31:0] speed_trap_speed;
  logic [3:0]  speed_trap_strobe;
  logic [15:0] lf = 16'h0015;  // random source, fixed seed
  int          failures = 0, n_checks = 0, cyc = 0, red_cyc = 0, hg_cyc = 0;
  logic        prev_hold = 1'b0, prev_rst = 1'b0, alarm_seen = 1'b0;
  wire  logic [2:0] ph = {phase_red_clr, phase_yellow, phase_green};
  // block under test
  rce_top #(.TICK_DIV(DIV)) i_dut (
    .clk, .rst_b, .use_programmed, .startup_vehicle_call_mask, .startup_pedestrian_call_mask,
    .startup_vehicle_call, .startup_pedestrian_call, .yellow_time, .red_time, .late_yellow_window,
    .clearance_extension_time, .red_clearance_cap, .phase_green, .phase_yellow, .phase_red_clr,
    .red_extend_detector, .speed_trap_enable, .speed_trap_group, .speed_threshold, .speed_trap_speed,
    .speed_trap_strobe, .red_hold, .red_extension_alarm, .warning_time, .coordinated, .force_off,
    .hold_green, .beacon_out, .terminate_concurrent);
  // far side: phase sequencer
  rce_phase_model #(.DIV(DIV)) i_seq (
    .clk, .rst_b, .yellow_time, .red_time, .force_off, .hold_green, .red_hold,
    .phase_green, .phase_yellow, .phase_red_clr);
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd
  // tick counts may be one off by divider phase
  function automatic logic [31:0] near(input logic [31:0] s, input logic [31:0] e);
    return (s + 1 >= e && s <= e + 1) ? e : s;
  endfunction : near
  // red length in ticks for each scenario kind
  function automatic logic [7:0] exp_red(input int k, input logic [7:0] rt, input logic [7:0] ex,
                                         input logic [7:0] cp);
    int e;
    case (k)
      1, 4: e = ex;
      3: e = cp;
      6: e = ex - 5;
      7: e = ex - 1;
      default: e = rt;
    endcase
    if (e < rt) e = rt;
    if (e > cp) e = cp;
    return 8'(e);
  endfunction : exp_red
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // wait for interval n (0 green, 1 yellow, 2 red), bounded
  task automatic wait_ph(input int n);
    int i;
    i = 0;
    while (ph[n] !== 1'b1 && i < 4000) begin
      @(posedge clk);
      i++;
    end
  endtask : wait_ph
  // per-cycle watch of levels and interval lengths
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_hold <= red_hold;
    prev_rst <= rst_b;
    if (phase_red_clr) red_cyc <= red_cyc + 1;
    if (phase_yellow) red_cyc <= 0;
    if (hold_green) hg_cyc <= hg_cyc + 1;
    if (force_off) hg_cyc <= 0;
    if (red_extension_alarm) alarm_seen <= 1'b1;
    if (phase_yellow) alarm_seen <= 1'b0;
    if (rst_b && prev_rst) begin
      chk(red_extension_alarm, prev_hold);
      chk(terminate_concurrent, hold_green && coordinated);
      if (phase_yellow || phase_red_clr) chk(beacon_out, 1);
    end
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end
  // release reset and look at the one-cycle startup calls
  task automatic startup(input logic up);
    use_programmed <= up;
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(startup_vehicle_call, up ? startup_vehicle_call_mask : 8'h00);
    chk(startup_pedestrian_call, up ? startup_pedestrian_call_mask : 8'h00);
    @(posedge clk);
    #1;
    chk({startup_vehicle_call, startup_pedestrian_call}, 16'h0000);
  endtask : startup
  // detector or trap actuation; kind 3 holds through red
  task automatic trig(input int k);
    if (k == 4 || k == 5) speed_trap_strobe <= 4'hf;
    else red_extend_detector <= 1'b1;
    repeat (3) @(posedge clk);
    while (k == 3 && phase_red_clr) @(posedge clk);
    speed_trap_strobe <= 4'h0;
    red_extend_detector <= 1'b0;
  endtask : trig
  // one termination: 0 none, 1 red, 2 zero window, 3 held, 4/5 trap hit/miss,
  // 6 window over yellow, 7/8 late in window/early before window
  task automatic run(input int k);
    logic [7:0]  rt, ex, cp, wt, th, er;
    logic [1:0]  g;
    logic [31:0] sp;
    rt = 8'h02 + 8'(rnd() % 3);
    ex = 8'h06 + 8'(rnd() % 7);
    cp = 8'h0a + 8'(rnd() % 6);
    wt = 8'(rnd() % 6);
    th = 8'h10 + 8'(rnd() % 200);
    g = 2'(rnd());
    sp = {rnd(), rnd()};
    if (k == 5) sp = '1;
    sp[g*8 +: 8] = (k == 5) ? th - 8'h01 : th;
    er = exp_red(k, rt, ex, cp);
    wait_ph(0);
    repeat (3) @(posedge clk);
    red_time <= rt;
    clearance_extension_time <= ex;
    red_clearance_cap <= cp;
    warning_time <= wt;
    speed_threshold <= th;
    speed_trap_group <= g;
    speed_trap_speed <= sp;
    speed_trap_enable <= (k == 4 || k == 5);
    late_yellow_window <= (k == 2) ? 8'h00 : ((k == 6) ? 8'h09 : 8'h02);
    coordinated <= ~coordinated;  // free and coordinated in turn
    force_off <= 1'b1;
    @(posedge clk);
    force_off <= 1'b0;
    #1;
    chk(hold_green, 1);
    chk(beacon_out, 1);
    wait_ph(1);
    chk(near(hg_cyc / DIV, wt), wt);
    if (k == 2 || k >= 6) begin
      repeat ((k == 2 || k == 7) ? 4 * DIV + 2 : 2) @(posedge clk);
      trig(k);
    end
    wait_ph(2);
    if (k == 1 || (k >= 3 && k <= 5)) begin
      @(posedge clk);
      trig(k);
    end
    wait_ph(0);
    repeat (2) @(posedge clk);
    #1;
    chk(beacon_out, 0);
    chk(near(red_cyc / DIV, er), er);
    if (er > rt + 1 || k == 0 || k == 2 || k == 5 || k == 8) chk(alarm_seen, er > rt);
  endtask : run
  // main sequence
  initial begin
    rst_b = 1'b0;
    use_programmed = 1'b1;
    startup_vehicle_call_mask = 8'(rnd());
    startup_pedestrian_call_mask = 8'(rnd());
    yellow_time = 8'h05;
    red_time = 8'h02;
    late_yellow_window = 8'h00;
    clearance_extension_time = 8'h00;
    red_clearance_cap = 8'h0a;
    speed_threshold = 8'h00;
    warning_time = 8'h00;
    speed_trap_group = 2'h0;
    speed_trap_speed = 32'h0;
    speed_trap_strobe = 4'h0;
    speed_trap_enable = 1'b0;
    red_extend_detector = 1'b0;
    coordinated = 1'b0;
    force_off = 1'b0;
    repeat (16) @(posedge clk);
    startup(1'b1);
    for (int i = 0; i < 27; i++) run(i % 9);
    // second reset in mid-run, startup source not programmed
    rst_b <= 1'b0;
    startup_vehicle_call_mask <= 8'(rnd());
    repeat (4) @(posedge clk);
    startup(1'b0);
    run(1);
    end_sim();
  end
endmodule : red_clearance_extender_tb_top
`default_nettype wire
